// File: hw/rrs_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "rrs_params.svh"
// executes reference, return, rotate and subtract-with-borrow
module rrs_exec (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] slot_byte,
    input wire logic [3:0] mem_nibble,
    input wire logic [3:0] stack_nibble,
    input wire logic [3:0] ea_init_unused,
    output logic op_ready,
    output logic [7:0] slot_addr,
    output logic [7:0] stack_addr,
    output logic [13:0] pc,
    output logic [7:0] sp,
    output logic [7:0] ea,
    output logic carry,
    output logic mem_bank_en,
    output logic reg_bank_en,
    output logic skip_next,
    output logic [1:0] ref_kind,
    output logic ref_exec
);
    logic rst_s1_q;
    logic rst_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    typedef struct packed {
        rrs_pkg::rrs_state_t st;
        logic [1:0] cyc;
        logic [13:0] pc;
        logic [7:0] sp;
        logic [7:0] ea;
        logic c;
        logic memory_bank_enable_flag;
        logic register_bank_enable_flag;
        logic sub4_prev;
        logic borrow_prev;
        logic skip;
        logic rdy;
        logic [7:0] slot;
        logic [7:0] saddr;
        logic [1:0] kind;
        logic rexec;
        logic [1:0] psel;
        logic dir_to_pair;
    } rrs_s_t;

    rrs_s_t s_q;
    rrs_s_t s_d;
    logic [7:0] pair_rd;
    logic pair_we;
    logic [7:0] pair_wd;

    rrs_pair_file u_pairs (
        .core_clk(core_clk),
        .rst_n(rst_q),
        .rd_sel(s_d.psel),
        .rd_data(pair_rd),
        .wr_en(pair_we),
        .wr_sel(s_q.psel),
        .wr_data(pair_wd)
    );

    function automatic logic [4:0] sub4(input logic [3:0] a, input logic [3:0] b,
                                        input logic ci);
        logic [4:0] r;
        r = {1'b0, a} - {1'b0, b} - {4'h0, ci};
        return r;
    endfunction

    // bit 8 of the result is the borrow out of the msb
    function automatic logic [8:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
        logic [8:0] r;
        r = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        return r;
    endfunction

    // second byte of the 8-bit forms; a set bit 0 is not one of them
    function automatic logic pair_form_ok(input logic [7:0] b);
        logic ok;
        ok = (b[7:3] == `RRS_OP2_EA_RR || b[7:3] == `RRS_OP2_RR_EA) && !b[0];
        return ok;
    endfunction

    // table reference opcodes occupy 20h..3fh
    function automatic logic is_ref_op(input logic [7:0] b);
        logic hit;
        hit = b[7:6] == 2'h0 && b[5];
        return hit;
    endfunction

    function automatic logic [1:0] slot_kind(input logic [7:0] first);
        logic [1:0] k;
        if (first[7:6] == `RRS_SLOT_CALL) begin
            k = rrs_pkg::REF_CALL;
        end else if (first[7:6] == `RRS_SLOT_JUMP) begin
            k = rrs_pkg::REF_JUMP;
        end else begin
            k = rrs_pkg::REF_EXEC;
        end
        return k;
    endfunction

    logic [4:0] nib_res;
    logic [8:0] byte_res;

    always_comb begin
        s_d = s_q;
        pair_we = 1'b0;
        pair_wd = 8'h0_000;
        nib_res = sub4(s_q.ea[3:0], mem_nibble, s_q.c);
        byte_res = 9'h0_000;
        s_d.skip = 1'b0;
        unique case (s_q.st)
            rrs_pkg::ST_FETCH: begin
                s_d.rdy = 1'b1;
                if (op_valid && s_q.rdy) begin
                    s_d.sub4_prev = 1'b0;
                    if (op_byte == `RRS_OP_SUB4) begin
                        s_d.ea[3:0] = nib_res[3:0];
                        s_d.c = nib_res[4];
                        s_d.sub4_prev = 1'b1;
                        s_d.borrow_prev = nib_res[4];
                        s_d.pc = s_q.pc + 14'h0_001;
                    end else if (op_byte == `RRS_OP_ROT) begin
                        s_d.ea[3:0] = {s_q.c, s_q.ea[3:1]};
                        s_d.c = s_q.ea[0];
                        s_d.pc = s_q.pc + 14'h0_001;
                    end else if (op_byte == `RRS_OP_RET) begin
                        s_d.st = rrs_pkg::ST_RET_A;
                        s_d.cyc = 2'h0;
                        s_d.saddr = s_q.sp;
                        s_d.rdy = 1'b0;
                    end else if (op_byte == `RRS_OP_PFX) begin
                        s_d.st = rrs_pkg::ST_SECOND;
                        s_d.pc = s_q.pc + 14'h0_001;
                        s_d.rdy = 1'b0;
                    end else if (is_ref_op(op_byte)) begin
                        // slot pairs are even, so low nibble bit 3 has no room
                        s_d.slot = {op_byte[7:4], op_byte[2:0], 1'b0};
                        s_d.st = rrs_pkg::ST_REF;
                        s_d.rdy = 1'b0;
                    end else begin
                        // add-immediate right after nibble subtract
                        if (s_q.sub4_prev && op_byte[7:4] == `RRS_ADS_HI) begin
                            s_d.skip = 1'b0;
                            s_d.pc = s_q.pc + (s_q.borrow_prev ? 14'h0_001 : 14'h0_002);
                        end else begin
                            s_d.pc = s_q.pc + 14'h0_001;
                        end
                    end
                end
            end
            rrs_pkg::ST_SECOND: begin
                s_d.rdy = 1'b1;
                if (op_valid && s_q.rdy) begin
                    s_d.psel = op_byte[2:1];
                    s_d.dir_to_pair = (op_byte[7:3] == `RRS_OP2_RR_EA);
                    s_d.st = rrs_pkg::ST_RET_B;
                    s_d.cyc = 2'h3;
                    s_d.rdy = 1'b0;
                    s_d.pc = s_q.pc + 14'h0_001;
                    // unknown second byte retires the prefix as a no-op
                    if (!pair_form_ok(op_byte)) begin
                        s_d.st = rrs_pkg::ST_FETCH;
                        s_d.rdy = 1'b1;
                    end
                end
            end
            rrs_pkg::ST_RET_A: begin
                // one stack nibble per step, frame order fixed
                s_d.cyc = s_q.cyc + 2'h1;
                s_d.saddr = s_q.saddr + 8'h0_001;
                unique case (s_q.cyc)
                    2'h0: s_d.pc[11:8] = stack_nibble;
                    2'h1: s_d.pc[13:12] = stack_nibble[1:0];
                    2'h2: s_d.pc[3:0] = stack_nibble;
                    2'h3: begin
                        s_d.pc[7:4] = stack_nibble;
                        s_d.st = rrs_pkg::ST_RET_B;
                        s_d.cyc = 2'h0;
                    end
                endcase
            end
            rrs_pkg::ST_RET_B: begin
                if (s_q.cyc == 2'h3) begin
                    // 8-bit subtract, second cycle
                    if (s_q.dir_to_pair) begin
                        byte_res = sub8(pair_rd, s_q.ea, s_q.c);
                        pair_we = 1'b1;
                        pair_wd = byte_res[7:0];
                    end else begin
                        byte_res = sub8(s_q.ea, pair_rd, s_q.c);
                        s_d.ea = byte_res[7:0];
                    end
                    s_d.c = byte_res[8];
                    s_d.sub4_prev = 1'b0;
                    s_d.st = rrs_pkg::ST_FETCH;
                    s_d.rdy = 1'b1;
                end else begin
                    s_d.memory_bank_enable_flag = stack_nibble[1];
                    s_d.register_bank_enable_flag = stack_nibble[0];
                    s_d.sp = s_q.sp + `RRS_SP_POP;
                    s_d.sub4_prev = 1'b0;
                    s_d.st = rrs_pkg::ST_FETCH;
                    s_d.rdy = 1'b1;
                end
            end
            rrs_pkg::ST_REF: begin
                s_d.kind = slot_kind(slot_byte);
                s_d.rexec = 1'b1;
                s_d.pc = s_q.pc + 14'h0_001;
                s_d.st = rrs_pkg::ST_FETCH;
                s_d.rdy = 1'b1;
            end
            default: begin
                s_d.st = rrs_pkg::ST_FETCH;
            end
        endcase
        if (s_q.st != rrs_pkg::ST_REF) begin
            s_d.rexec = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        op_ready = s_q.rdy;
        slot_addr = s_q.slot;
        stack_addr = s_q.saddr;
        pc = s_q.pc;
        sp = s_q.sp;
        ea = s_q.ea;
        carry = s_q.c;
        mem_bank_en = s_q.memory_bank_enable_flag;
        reg_bank_en = s_q.register_bank_enable_flag;
        skip_next = s_q.skip;
        ref_kind = s_q.kind;
        ref_exec = s_q.rexec;
    end
endmodule
`default_nettype wire

// File: hw/rrs_params.svh
`ifndef RRS_PARAMS_SVH
`define RRS_PARAMS_SVH
`define RRS_OP_RET 8'h0_0C5
`define RRS_OP_ROT 8'h0_088
`define RRS_OP_SUB4 8'h0_03C
`define RRS_OP_PFX 8'h0_0DC
`define RRS_OP2_EA_RR 5'h1_9
`define RRS_OP2_RR_EA 5'h1_8
`define RRS_ADS_HI 4'h0_A
`define RRS_SLOT_CALL 2'h1
`define RRS_SLOT_JUMP 2'h0
`define RRS_SP_POP 8'h0_006
`define RRS_RET_CYC 2'h2
`endif

// File: hw/rrs_pkg.sv
package rrs_pkg;
    typedef enum logic [2:0] {
        ST_FETCH,
        ST_SECOND,
        ST_RET_A,
        ST_RET_B,
        ST_REF
    } rrs_state_t;
    typedef enum logic [1:0] {
        REF_EXEC,
        REF_JUMP,
        REF_CALL
    } rrs_ref_kind_t;
endpackage

// File: hw/rrs_pair_file.sv
`timescale 1ns/1ps
`default_nettype none
// four 8-bit register pairs, registered read port
module rrs_pair_file (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] rd_sel,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [7:0] wr_data
);
    logic [7:0] mem_q [4];
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                mem_q[i] <= 8'h0_000;
            end
            rd_data <= 8'h0_000;
        end else begin
            if (wr_en) begin
                mem_q[wr_sel] <= wr_data;
            end
            rd_data <= (wr_en && wr_sel == rd_sel) ? wr_data : mem_q[rd_sel];
        end
    end
endmodule
`default_nettype wire

// File: verification/rrs_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
module rrs_exec_props (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] slot_byte,
    input wire logic [3:0] mem_nibble,
    input wire logic op_ready,
    input wire logic [7:0] slot_addr,
    input wire logic [7:0] sp,
    input wire logic [13:0] pc,
    input wire logic [7:0] ea,
    input wire logic carry,
    input wire logic skip_next,
    input wire logic [1:0] ref_kind,
    input wire logic ref_exec
);
    wire taken = op_valid && op_ready;
    logic [7:0] ref_op_q;
    logic [7:0] sp_ret_q;
    logic ret_q;
    logic sub_prev_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_op_q <= 8'h00;
            sp_ret_q <= 8'h00;
            ret_q <= 1'b0;
        end else if (taken && op_byte == 8'hC5) begin
            sp_ret_q <= sp;
            ret_q <= 1'b1;
        end else begin
            if (taken && op_byte[7:5] == 3'b001) ref_op_q <= op_byte;
            if (op_ready) ret_q <= 1'b0;
        end
    end
    // remembers whether the last accepted opcode was the nibble subtract
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sub_prev_q <= 1'b0;
        end else if (taken) begin
            sub_prev_q <= (op_byte == 8'h3C);
        end
    end
    a_rot_result: assert property (
        taken && op_byte == 8'h88 |=> ea[3:0] == {$past(carry), $past(ea[3:1])}
        && carry == $past(ea[0]) && ea[7:4] == $past(ea[7:4]))
        else $error("rotate result wrong");
    a_sub_nibble: assert property (
        taken && op_byte == 8'h3C |=> {carry, ea[3:0]} ==
        {1'b0, $past(ea[3:0])} - {1'b0, $past(mem_nibble)} - $past(carry))
        else $error("nibble subtract wrong");
    a_sub_noskip: assert property (
        taken && op_byte == 8'h3C |=> !skip_next)
        else $error("subtract skipped");
    a_ret_busy: assert property (
        taken && op_byte == 8'hC5 |=> !op_ready ##[1:8] op_ready)
        else $error("return length wrong");
    a_ret_sp: assert property (
        ret_q && $rose(op_ready) |-> sp == sp_ret_q + 8'h06)
        else $error("return stack pointer wrong");
    a_ref_addr: assert property (
        ref_exec |-> slot_addr == {ref_op_q[7:4], ref_op_q[2:0], 1'b0})
        else $error("slot address wrong");
    a_ref_kind: assert property (
        ref_exec |-> ref_kind ==
        (slot_byte[7:6] == 2'b01 ? 2'd2 : slot_byte[7:6] == 2'b00 ? 2'd1 : 2'd0))
        else $error("slot kind wrong");
    a_ref_pulse: assert property (
        ref_exec |=> !ref_exec)
        else $error("kind strobe too long");
    a_sub_addskip: assert property (
        taken && sub_prev_q && op_byte[7:4] == 4'hA |=>
        pc == $past(pc) + ($past(carry) ? 14'h0001 : 14'h0002))
        else $error("add after subtract skip wrong");
endmodule
`default_nettype wire

// File: verification/rrs_mem.sv
`timescale 1ns/1ps
`default_nettype none
// program bytes and stack nibbles, loaded by the bench before reset ends
module rrs_mem (
    input wire logic [7:0] slot_addr,
    input wire logic [7:0] stack_addr,
    output logic [7:0] slot_byte,
    output logic [3:0] stack_nibble
);
    logic [7:0] rom [256];
    logic [3:0] ram [256];
    assign slot_byte = rom[slot_addr];
    assign stack_nibble = ram[stack_addr];
endmodule
`default_nettype wire

// File: verification/rrs_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("FAIL %0t mismatch", $time); end end
module rrs_exec_bench;
    logic core_clk = 0;
    logic arst_n = 0;
    logic op_valid = 0;
    logic [7:0] op_byte = 8'h00;
    logic [3:0] mem_nibble = 4'h0;
    wire logic [7:0] slot_byte, slot_addr, stack_addr, sp, ea;
    wire logic [3:0] stack_nibble;
    wire logic [13:0] pc;
    wire logic op_ready, carry, mem_bank_en, reg_bank_en, skip_next, ref_exec;
    wire logic [1:0] ref_kind;
    int err_total = 0;
    int cmp_count = 0;
    int k;
    logic [7:0] m_ea, m_sp, b, op;
    logic [7:0] pr [4];
    logic m_c;
    logic [1:0] rr;
    logic [8:0] r;
    logic [13:0] m_pc;
    logic [7:0] seen_addr;
    logic [1:0] seen_kind;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (ref_exec === 1'b1) begin
        seen_addr <= slot_addr;
        seen_kind <= ref_kind;
    end
    rrs_exec u_rrs_exec (.core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid),
        .op_byte(op_byte), .slot_byte(slot_byte), .mem_nibble(mem_nibble),
        .stack_nibble(stack_nibble), .ea_init_unused(4'h0), .op_ready(op_ready),
        .slot_addr(slot_addr), .stack_addr(stack_addr), .pc(pc), .sp(sp), .ea(ea),
        .carry(carry), .mem_bank_en(mem_bank_en), .reg_bank_en(reg_bank_en),
        .skip_next(skip_next), .ref_kind(ref_kind), .ref_exec(ref_exec));
    rrs_mem u_rrs_mem (.slot_addr(slot_addr), .stack_addr(stack_addr),
        .slot_byte(slot_byte), .stack_nibble(stack_nibble));
    function automatic logic [8:0] sbw(input logic [7:0] d, input logic [7:0] s,
        input logic c, input logic wide);
        sbw = wide ? {1'b0, d} - {1'b0, s} - c
            : {4'h0, {1'b0, d[3:0]} - {1'b0, s[3:0]} - c};
    endfunction
    task automatic issue(input logic [7:0] v);
        int n;
        @(negedge core_clk);
        op_valid = 1'b1;
        op_byte = v;
        n = 0;
        // ready is read where it is settled; the next rising edge takes the byte
        while (op_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        op_valid = 1'b0;
        // settle: the 8-bit forms land one cycle after their second byte
        repeat (2) @(negedge core_clk);
        while (op_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 50) begin
            err_total++;
            $display("FAIL %0t no ready", $time);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #500000;
        err_total++;
        $display("FAIL %0t watchdog", $time);
        summarize();
    end
    initial begin
        void'($urandom(16704));
        for (int i = 0; i < 256; i++) begin
            u_rrs_mem.rom[i] = 8'($urandom);
            u_rrs_mem.ram[i] = 4'($urandom);
        end
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        m_ea = 8'h00;
        m_c = 1'b0;
        m_sp = 8'h00;
        pr = '{default: 8'h00};
        repeat (2) begin
            b = m_sp;
            issue(8'hC5);
            m_sp = m_sp + 8'h06;
            m_pc = {u_rrs_mem.ram[b + 8'd1][1:0], u_rrs_mem.ram[b],
                u_rrs_mem.ram[b + 8'd3], u_rrs_mem.ram[b + 8'd2]};
            `CHK(pc, m_pc)
            `CHK(sp, m_sp)
            `CHK({mem_bank_en, reg_bank_en}, u_rrs_mem.ram[b + 8'd4][1:0])
        end
        $display("return test done");
        for (int i = 0; i < 40; i++) begin
            k = $urandom % 4;
            rr = 2'($urandom);
            mem_nibble = 4'($urandom);
            // first pass forces a borrow out of an all-zero accumulator
            if (i == 0) begin
                k = 0;
                mem_nibble = 4'hF;
            end
            case (k)
                0: begin
                    r = sbw(m_ea, {4'h0, mem_nibble}, m_c, 1'b0);
                    m_ea[3:0] = r[3:0];
                    m_c = r[4];
                    issue(8'h3C);
                end
                1: begin
                    {m_ea[3:0], m_c} = {m_c, m_ea[3:0]};
                    issue(8'h88);
                end
                2: begin
                    r = sbw(m_ea, pr[rr], m_c, 1'b1);
                    {m_c, m_ea} = r;
                    issue(8'hDC);
                    issue({5'h19, rr, 1'b0});
                end
                default: begin
                    r = sbw(pr[rr], m_ea, m_c, 1'b1);
                    {m_c, pr[rr]} = r;
                    issue(8'hDC);
                    issue({5'h18, rr, 1'b0});
                end
            endcase
            `CHK(ea, m_ea)
            `CHK(carry, m_c)
            `CHK(skip_next, 1'b0)
        end
        $display("arithmetic test done");
        // add-immediate straight after the nibble subtract
        for (int i = 0; i < 4; i++) begin
            mem_nibble = (i == 0) ? 4'hF : 4'($urandom);
            r = sbw(m_ea, {4'h0, mem_nibble}, m_c, 1'b0);
            m_ea[3:0] = r[3:0];
            m_c = r[4];
            issue(8'h3C);
            m_pc = pc;
            issue(8'hA5);
            `CHK(pc, m_pc + (m_c ? 14'h0001 : 14'h0002))
            `CHK(ea, m_ea)
        end
        $display("skip test done");
        for (int i = 0; i < 16; i++) begin
            op = {3'b001, i[3], 1'b0, i[2:0]};
            b = {op[7:4], op[2:0], 1'b0};
            u_rrs_mem.rom[b][7:6] = 2'(i % 4);
            seen_kind = 2'bxx;
            issue(op);
            `CHK(seen_addr, b)
            `CHK(seen_kind, (i % 4 == 1) ? 2'd2 : (i % 4 == 0) ? 2'd1 : 2'd0)
        end
        $display("reference test done");
        summarize();
    end
endmodule
bind rrs_exec rrs_exec_props u_rrs_exec_props (.*);
`default_nettype wire
